/* src/arc_ctrl.sv */
// Purpose: register bank for temperature calibration, ADC reference and regulator control
// Assumes: internal 8-bit register bus, one-cycle write strobe, read data registered
// Notes: calibration word is captured from the nonvolatile input after reset release
// ************************************************************
// module
// ************************************************************
// Overview of operation
// - The high calibration byte at 0xa3 shows calibration bits 9 to 2, left-justified.
// - The low calibration byte at 0xa2 shows calibration bits 1 and 0 in positions 7 and 6.
// - Bits 5 to 0 of the low calibration byte read zero and ignore writes.
// - The calibration word is the ADC count of the sensor at 0 C with the regulator as reference.
// - The reference control register at 0xd1 resets to zero and bits 7 to 5 read zero.
// - With override bit 4 set the reference is the internal regulator regardless of select.
// - Without override, select bit 3 picks the reference pin at 0 and the supply at 1.
// - Bit 2 switches the temperature sensor off at 0 and on at 1.
// - Bits 1 and 0 of the reference control register read zero and ignore writes.
// - By default the regulator stays powered in stop mode so any reset source works.
// - With stop configuration set, stop mode shuts the regulator and power network down.
// - The regulator control register at 0xc7 holds stop configuration, bypass and memory power bits.
// - Bypass set turns the regulator off so the core runs from the supply pin.
module arc_ctrl
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [ARC_CAL_W-1:0] nv_cal_i,
  input wire logic stop_req_i,
  output logic [7:0] rdata_o,
  output arc_ref_src_e ref_source_o,
  output logic temp_sensor_on_o,
  output logic regulator_on_o,
  output logic power_net_on_o,
  output logic memory_power_ctrl_o
);
  // ************************************************************
  // storage
  // ************************************************************
  logic [ARC_CAL_W-1:0] cal_word_r;
  logic cal_loaded_r;
  logic [7:0] ref_ctrl_r;
  logic [7:0] reg_ctrl_r;
  logic [7:0] rdata_nxt;
  logic stop_cfg;
  logic bypass;

  // ************************************************************
  // write decode
  // ************************************************************
  logic wr_cal_high;
  logic wr_cal_low;
  logic wr_ref;
  logic wr_reg;

  // one strobe per register keeps the write processes and the checks below in step
  assign wr_cal_high = wr_i && (addr_i == ARC_ADDR_CAL_HIGH);
  assign wr_cal_low = wr_i && (addr_i == ARC_ADDR_CAL_LOW);
  assign wr_ref = wr_i && (addr_i == ARC_ADDR_REF_CTRL);
  assign wr_reg = wr_i && (addr_i == ARC_ADDR_REG_CTRL);

  // control fields named once so the power logic reads like the rules
  assign stop_cfg = reg_ctrl_r[ARC_REG_STOP_BIT];
  assign bypass = reg_ctrl_r[ARC_REG_BYP_BIT];

  // nonvolatile value cannot be taken under async reset, so catch it on the first edge after release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_loaded_r <= 1'b0;
    end else begin
      cal_loaded_r <= 1'b1;
    end
  end

  // calibration word: factory load first, then software may overwrite
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_word_r <= '0;
    end else if (!cal_loaded_r) begin
      cal_word_r <= nv_cal_i;
    end else if (wr_cal_high) begin
      cal_word_r[ARC_CAL_W-1:ARC_CAL_SPLIT] <= wdata_i;
    end else if (wr_cal_low) begin
      cal_word_r[ARC_CAL_SPLIT-1:0] <= wdata_i[ARC_LOW_CAL_HI:ARC_LOW_CAL_LO];
    end
  end

  // reference control keeps only its writable bits
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_ctrl_r <= ARC_REF_RESET;
    end else if (wr_ref) begin
      ref_ctrl_r <= wdata_i & ARC_REF_WMASK;
    end
  end

  // regulator control; bypass safety is software's job, hardware does not check supply
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_ctrl_r <= ARC_REG_RESET;
    end else if (wr_reg) begin
      reg_ctrl_r <= wdata_i & ARC_REG_WMASK;
    end
  end

  // read decode
  always_comb begin
    if (addr_i == ARC_ADDR_CAL_HIGH) begin
      rdata_nxt = cal_word_r[ARC_CAL_W-1:ARC_CAL_SPLIT];
    end else if (addr_i == ARC_ADDR_CAL_LOW) begin
      rdata_nxt = {cal_word_r[ARC_CAL_SPLIT-1:0], ARC_LOW_ZERO};
    end else if (addr_i == ARC_ADDR_REF_CTRL) begin
      rdata_nxt = ref_ctrl_r;
    end else if (addr_i == ARC_ADDR_REG_CTRL) begin
      rdata_nxt = reg_ctrl_r;
    end else begin
      rdata_nxt = ARC_READ_ZERO;
    end
  end

  // read data captured one cycle after the read strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= ARC_READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  // ************************************************************
  // analog controls
  // ************************************************************
  arc_ref_mux u_ref_mux (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .override_i(ref_ctrl_r[ARC_REF_OVR_BIT]),
    .select_i(ref_ctrl_r[ARC_REF_SEL_BIT]),
    .source_o(ref_source_o)
  );

  // sensor enable, memory power and regulator power
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_sensor_on_o <= 1'b0;
      memory_power_ctrl_o <= 1'b0;
      regulator_on_o <= 1'b1;
      power_net_on_o <= 1'b1;
    end else begin
      temp_sensor_on_o <= ref_ctrl_r[ARC_REF_TEMP_BIT];
      memory_power_ctrl_o <= reg_ctrl_r[ARC_REG_MPC_BIT];
      // regulator off on bypass, or in stop when configured to shut down
      regulator_on_o <= !bypass && !(stop_req_i && stop_cfg);
      power_net_on_o <= !(stop_req_i && stop_cfg);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // override must win over select whatever the select bit holds
  a_ref_override: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ref_ctrl_r[ARC_REF_OVR_BIT] |=> ref_source_o == ARC_REF_REGULATOR)
    else $error("override did not select regulator");

  // without override the select bit alone picks pin or supply
  a_ref_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ref_ctrl_r[ARC_REF_OVR_BIT] |=>
      ref_source_o == ($past(ref_ctrl_r[ARC_REF_SEL_BIT]) ? ARC_REF_SUPPLY : ARC_REF_PIN))
    else $error("select bit did not steer reference");

  // sensor enable follows its bit one cycle later
  a_temp_enable: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 temp_sensor_on_o == $past(ref_ctrl_r[ARC_REF_TEMP_BIT]))
    else $error("sensor enable mismatch");

  // upper reference bits never read back as ones
  a_ref_unused: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_REF_CTRL) |=> rdata_o[7:5] == 3'h0)
    else $error("reference upper bits not zero");

  // lowest reference bits never read back as ones
  a_ref_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_REF_CTRL) |=> rdata_o[1:0] == 2'h0)
    else $error("reference low bits not zero");

  // unused calibration low bits read zero even after a write of ones
  a_low_byte_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_CAL_LOW) |=> rdata_o[5:0] == ARC_LOW_ZERO)
    else $error("calibration low unused bits not zero");

  // high byte carries the upper part of the word, left-justified
  a_high_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_CAL_HIGH) |=> rdata_o == $past(cal_word_r[ARC_CAL_W-1:ARC_CAL_SPLIT]))
    else $error("calibration high byte mismatch");

  // low byte carries the two lowest word bits at its top
  a_low_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_CAL_LOW) |=> rdata_o[7:6] == $past(cal_word_r[ARC_CAL_SPLIT-1:0]))
    else $error("calibration low bits mismatch");

  // factory word lands on the first edge after reset release
  a_factory_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cal_loaded_r |=> cal_word_r == $past(nv_cal_i))
    else $error("factory calibration not loaded");

  // load happens once; a later write must not be overridden again
  a_cal_load_once: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cal_loaded_r |=> cal_loaded_r)
    else $error("factory load repeated");

  // software write of the high byte reaches the upper word bits
  a_cal_high_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_cal_high && cal_loaded_r) |=> cal_word_r[ARC_CAL_W-1:ARC_CAL_SPLIT] == $past(wdata_i))
    else $error("calibration high write lost");

  // software write of the low byte keeps only its top two bits
  a_cal_low_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_cal_low && cal_loaded_r) |=>
      cal_word_r[ARC_CAL_SPLIT-1:0] == $past(wdata_i[ARC_LOW_CAL_HI:ARC_LOW_CAL_LO]))
    else $error("calibration low write lost");

  // default stop keeps the regulator and network alive for any reset source
  a_stop_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (stop_req_i && !stop_cfg && !bypass) |=> regulator_on_o && power_net_on_o)
    else $error("regulator dropped in default stop");

  // outside stop the power network is never cut
  a_power_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !stop_req_i |=> power_net_on_o)
    else $error("power network off outside stop");

  // configured stop shuts both regulator and network
  a_stop_shut: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (stop_req_i && stop_cfg) |=> !regulator_on_o && !power_net_on_o)
    else $error("regulator not shut in configured stop");

  // bypass always turns the regulator off
  a_bypass_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bypass |=> !regulator_on_o)
    else $error("bypass left regulator on");

  // bypass clear and no stop keeps the regulator running
  a_regulator_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!stop_req_i && !bypass) |=> regulator_on_o)
    else $error("regulator off in normal mode");

  // regulator control keeps only its writable bits
  a_reg_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_reg |=> reg_ctrl_r == ($past(wdata_i) & ARC_REG_WMASK))
    else $error("regulator control write lost");

  // regulator control only changes on its own write
  a_reg_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !wr_reg |=> $stable(reg_ctrl_r))
    else $error("regulator control changed without write");

  // reserved regulator bits read back as zero
  a_reg_reserved: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_REG_CTRL) |=> (rdata_o & ~ARC_REG_WMASK) == ARC_READ_ZERO)
    else $error("regulator reserved bits not zero");

  // regulator control reads back what it holds
  a_reg_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_REG_CTRL) |=> rdata_o == $past(reg_ctrl_r))
    else $error("regulator control read mismatch");

  // memory power output follows its bit one cycle later
  a_mpc_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 memory_power_ctrl_o == $past(reg_ctrl_r[ARC_REG_MPC_BIT]))
    else $error("memory power control mismatch");

  // reference control keeps only its writable bits
  a_ref_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_ref |=> ref_ctrl_r == ($past(wdata_i) & ARC_REF_WMASK))
    else $error("reference control write lost");

  // reference control only changes on its own write
  a_ref_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !wr_ref |=> $stable(ref_ctrl_r))
    else $error("reference control changed without write");

  // reference control reads back what it holds
  a_ref_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ARC_ADDR_REF_CTRL) |=> rdata_o == $past(ref_ctrl_r))
    else $error("reference control read mismatch");
endmodule

/* src/arc_pkg.sv */
// Purpose: shared constants for the analog reference and regulator control registers
// Assumes: 8-bit special-function register bus, byte addresses
// Notes: bit positions and reset values are named here so logic holds no bare numbers
package arc_pkg;
  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ARC_ADDR_CAL_LOW = 8'ha2;
  localparam logic [7:0] ARC_ADDR_CAL_HIGH = 8'ha3;
  localparam logic [7:0] ARC_ADDR_REF_CTRL = 8'hd1;
  localparam logic [7:0] ARC_ADDR_REG_CTRL = 8'hc7;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ARC_CAL_W = 10;
  localparam int ARC_CAL_SPLIT = 2;
  localparam int ARC_LOW_CAL_HI = 7;
  localparam int ARC_LOW_CAL_LO = 6;
  localparam int ARC_REF_OVR_BIT = 4;
  localparam int ARC_REF_SEL_BIT = 3;
  localparam int ARC_REF_TEMP_BIT = 2;
  localparam int ARC_REG_STOP_BIT = 7;
  localparam int ARC_REG_BYP_BIT = 6;
  localparam int ARC_REG_MPC_BIT = 0;
  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [7:0] ARC_REF_RESET = 8'h00;
  localparam logic [7:0] ARC_REG_RESET = 8'h00;
  localparam logic [7:0] ARC_REF_WMASK = 8'h1c;
  localparam logic [7:0] ARC_REG_WMASK = 8'hc1;
  localparam logic [7:0] ARC_READ_ZERO = 8'h00;
  localparam logic [5:0] ARC_LOW_ZERO = 6'h00;
  // reference mux selections
  typedef enum logic [1:0] {
    ARC_REF_PIN = 2'b00,
    ARC_REF_SUPPLY = 2'b01,
    ARC_REF_REGULATOR = 2'b10
  } arc_ref_src_e;
endpackage

/* src/arc_ref_mux.sv */
// Purpose: decodes the reference source from override and select bits
// Assumes: inputs from registers on the same clock
// Notes: registered output so the top drives it straight from a flip-flop
module arc_ref_mux
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic override_i,
  input wire logic select_i,
  output arc_ref_src_e source_o
);
  // override beats the select bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      source_o <= ARC_REF_PIN;
    end else if (override_i) begin
      source_o <= ARC_REF_REGULATOR;
    end else if (select_i) begin
      source_o <= ARC_REF_SUPPLY;
    end else begin
      source_o <= ARC_REF_PIN;
    end
  end
endmodule

/* tb/tb_arc_ctrl.sv */
// Purpose: self-checking bench for the calibration, reference and regulator control registers
// Assumes: reads answer on the read edge and are checked at the next falling edge, analog outputs lag the register by one cycle
// Notes: expected read data travels in a queue; a monitor pops it when the answer is due
module tb_arc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import arc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [ARC_CAL_W-1:0] nv_cal_i = '0;
  logic stop_req_i = 1'b0;
  logic [7:0] rdata_o;
  arc_ref_src_e ref_source_o;
  logic temp_sensor_on_o, regulator_on_o, power_net_on_o, memory_power_ctrl_o;
  logic [7:0] exp_q[$];
  logic pend = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] d;
  logic stp;
  arc_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .nv_cal_i(nv_cal_i), .stop_req_i(stop_req_i), .rdata_o(rdata_o),
    .ref_source_o(ref_source_o), .temp_sensor_on_o(temp_sensor_on_o), .regulator_on_o(regulator_on_o),
    .power_net_on_o(power_net_on_o), .memory_power_ctrl_o(memory_power_ctrl_o));
  // ************************************************************
  // clock, compare and closing
  // ************************************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ************************************************************
  // bus tasks: each drives both strobes so back-to-back calls never double-assign
  // ************************************************************
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    rd_i = 1'b0;
    @(posedge clk_i);
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr_i = a;
    wr_i = 1'b0;
    rd_i = 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_i);
  endtask
  // idle one cycle so the one-cycle output lag has landed, then compare outputs
  task automatic ana(input logic [1:0] src, input logic t, input logic rg, input logic pn, input logic mp);
    @(negedge clk_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
    @(negedge clk_i);
    chk({6'h00, ref_source_o}, {6'h00, src});
    chk({7'h00, temp_sensor_on_o}, {7'h00, t});
    chk({7'h00, regulator_on_o}, {7'h00, rg});
    chk({7'h00, power_net_on_o}, {7'h00, pn});
    chk({7'h00, memory_power_ctrl_o}, {7'h00, mp});
  endtask
  // monitor: read data is due in the cycle after the read edge
  always @(posedge clk_i) pend <= rd_i;
  always @(negedge clk_i) begin
    if (pend) begin
      if (exp_q.size() == 0) chk(rdata_o, 8'hxx);
      else chk(rdata_o, exp_q.pop_front());
    end
  end
  // watchdog sized well above the hundred or so cycles the sequence needs
  initial begin
    #(3000 * 40);
    miscompares++;
    stop_test();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(2923));
    nv_cal_i = ARC_CAL_W'($urandom);
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    @(posedge clk_i);
    // reset values, factory word split left-justified
    bus_rd(ARC_ADDR_CAL_HIGH, nv_cal_i[9:2]);
    bus_rd(ARC_ADDR_CAL_LOW, {nv_cal_i[1:0], 6'h00});
    bus_rd(ARC_ADDR_REF_CTRL, ARC_REF_RESET);
    bus_rd(ARC_ADDR_REG_CTRL, ARC_REG_RESET);
    ana(ARC_REF_PIN, 1'b0, 1'b1, 1'b1, 1'b0);
    // calibration bytes: unused low bits ignore writes
    bus_wr(ARC_ADDR_CAL_LOW, 8'hff);
    d = 8'($urandom);
    bus_wr(ARC_ADDR_CAL_HIGH, d);
    bus_rd(ARC_ADDR_CAL_LOW, 8'hc0);
    bus_rd(ARC_ADDR_CAL_HIGH, d);
    // unmapped reads return zero
    bus_rd(8'h00, 8'h00);
    bus_rd(8'hd0, 8'h00);
    // reference control: override beats select, unused bits read zero
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'he8 : (i == 2) ? 8'h04 : (i == 3) ? 8'h03 : 8'($urandom);
      bus_wr(ARC_ADDR_REF_CTRL, d);
      bus_rd(ARC_ADDR_REF_CTRL, d & 8'h1c);
      ana(d[4] ? ARC_REF_REGULATOR : d[3] ? ARC_REF_SUPPLY : ARC_REF_PIN, d[2], 1'b1, 1'b1, 1'b0);
    end
    bus_wr(ARC_ADDR_REF_CTRL, 8'h00);
    // regulator control against stop mode
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : (i == 2) ? 8'hff : (i == 3) ? 8'h00 : 8'($urandom);
      stp = (i < 4) ? 1'b1 : 1'($urandom);
      @(negedge clk_i);
      stop_req_i = stp;
      bus_wr(ARC_ADDR_REG_CTRL, d); // bypass is set here only as a modelled external-supply case
      bus_rd(ARC_ADDR_REG_CTRL, d & 8'hc1);
      ana(ARC_REF_PIN, 1'b0, ~(d[6] | (stp & d[7])), ~(stp & d[7]), d[0]);
    end
    // mid-run reset returns the control registers to zero
    bus_wr(ARC_ADDR_REF_CTRL, 8'h1c);
    @(negedge clk_i);
    wr_i = 1'b0;
    stop_req_i = 1'b0;
    nrst_i = 1'b0;
    @(negedge clk_i);
    nrst_i = 1'b1;
    @(posedge clk_i);
    bus_rd(ARC_ADDR_REF_CTRL, ARC_REF_RESET);
    bus_rd(ARC_ADDR_REG_CTRL, ARC_REG_RESET);
    ana(ARC_REF_PIN, 1'b0, 1'b1, 1'b1, 1'b0);
    stop_test();
  end
endmodule
